// file: hw/mode_select_pkg.sv
// package for the mode select and program port block
// shared by the top level and the timer unit; no imports are used
package mode_select_pkg;

    // operating modes chosen from the static control pin levels
    typedef enum logic [1:0] {
        MODE_HOLD = 2'b00,
        MODE_PROG = 2'b01,
        MODE_WORK = 2'b10
    } op_mode_e;

    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned MEM_DEPTH     = 4096;
    localparam int unsigned CONF_W        = 4;
    localparam logic [11:0] FUZZY_LIMIT   = 12'h0400;   // membership data below this
    localparam logic [11:0] ADDR_RST_VAL  = 12'h0000;
    localparam logic [3:0]  CONF_RST_VAL  = 4'h0;
    localparam logic [7:0]  COUNT_RST_VAL = 8'h00;
    localparam int unsigned NUM_PWM       = 3;

    // bit positions of the synchronised pin bus
    localparam int unsigned SYN_RESET_N = 0;
    localparam int unsigned SYN_TEST    = 1;
    localparam int unsigned SYN_VPP     = 2;
    localparam int unsigned SYN_PA_LSB  = 3;
    localparam int unsigned SYN_PB_LSB  = 11;
    localparam int unsigned SYN_PC_LSB  = 18;
    localparam int unsigned SYN_W       = 22;

    // port pin roles
    localparam int unsigned PB_ADDR_CLR  = 0;
    localparam int unsigned PB_ADDR_INC  = 1;
    localparam int unsigned PB_CONF_CLR  = 2;
    localparam int unsigned PB_CONF_INC  = 3;
    localparam int unsigned PA_T0_CLEAR  = 0;
    localparam int unsigned PA_T0_RUN    = 4;
    localparam int unsigned PA_T0_CLOCK  = 5;
    localparam int unsigned PC_PHASE_IRQ = 0;

    // core side control of the general purpose pins
    typedef struct packed {
        logic [7:0] dir_a;
        logic [6:0] dir_b;
        logic [3:0] dir_c;
        logic [7:0] out_a;
        logic [6:0] out_b;
        logic [3:0] out_c;
        logic       b7_owns_pin;   // port b bit 7 drives the shared pin
    } port_ctl_s;

    // core side set-up of one timer/pwm unit
    typedef struct packed {
        logic       enable;
        logic       wave_on_pins;
        logic [7:0] period;
        logic [7:0] duty;
    } pwm_cfg_s;

endpackage

// file: hw/pin_sync.sv
// two flip-flop synchroniser for a bus of independent pin levels
// assumes each bit is a slow level; no bus coherence is promised
`timescale 1ns/1ns
module pin_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_ff;

    // first stage is read only by the second
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            meta_ff <= '0;
            o_sync  <= '0;
        end else begin
            meta_ff <= i_async;
            o_sync  <= meta_ff;
        end
    end

endmodule // pin_sync

// file: hw/pwm_timer_unit.sv
// one 8-bit timer/pwm unit with true and complementary wave outputs
// assumes clear, tick and gate are already in the i_clock domain
`timescale 1ns/1ns
module pwm_timer_unit #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic             i_enable,
    input  wire logic             i_clear_n,
    input  wire logic             i_tick,
    input  wire logic [WIDTH-1:0] i_period,
    input  wire logic [WIDTH-1:0] i_duty,
    output logic      [WIDTH-1:0] o_count,
    output logic                  o_wave,
    output logic                  o_wave_n
);

    // counter; a low clear level overrides counting
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_count <= mode_select_pkg::COUNT_RST_VAL;
        end else if (!i_clear_n || !i_enable) begin
            o_count <= mode_select_pkg::COUNT_RST_VAL;     // RULE12
        end else if (i_tick) begin
            o_count <= (o_count >= i_period) ? '0 : o_count + 1'b1;
        end
    end

    // both polarities from flops so they never overlap by a gate delay
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_wave   <= 1'b0;
            o_wave_n <= 1'b0;
        end else begin
            o_wave   <= i_enable && (o_count < i_duty);
            o_wave_n <= i_enable && !(o_count < i_duty);  // RULE15
        end
    end

    chk_timer_clear: assert property (  // RULE12
        @(posedge i_clock) disable iff (i_rst)
        !i_clear_n |=> o_count == '0)
        else $error("timer count not cleared by low clear input");

    chk_wave_pair: assert property (  // RULE15
        @(posedge i_clock) disable iff (i_rst)
        i_enable && $past(i_enable) |-> o_wave != o_wave_n)
        else $error("true and complementary waves not opposite");

endmodule // pwm_timer_unit

// file: hw/mode_select_prog_port.sv
// operating mode select, program memory loading port and working pin roles
// assumes a core that fetches from o_fetch_data and sets up ports and timers;
// all pin inputs are asynchronous and pass pin_sync before use
`timescale 1ns/1ns

// Notes on behaviour
// RULE1 - two modes from reset and supply levels
// RULE2 - programmer: reset low, test low, supply high
// RULE3 - core held in reset before programming writes
// RULE4 - increment pulse advances address; data on port a
// RULE5 - port b low four are memory controls
// RULE6 - port a carries data both ways
// RULE7 - working needs reset high, test, supply low
// RULE8 - reset restarts program from loaded memory
// RULE9 - first 1024 locations hold membership data
// RULE10 - test pin held low in both phases
// RULE11 - avoid 101010 on port a while reset low
// RULE12 - timer 0 clear pin active low
// RULE13 - timer 0 internal or external clock
// RULE14 - timer 0 external run gate
// RULE15 - true on port c, complement on port a
// RULE16 - every port pin input or output
// RULE17 - port a and b bit 7 share pin
// RULE18 - interrupt pin event starts service routine
// RULE19 - all low holds reset, no programming
// RULE20 - address steps once per rising strobe, clears
module mode_select_prog_port #(
    parameter int unsigned DEPTH = mode_select_pkg::MEM_DEPTH
) (
    input  wire logic                                i_clock,
    input  wire logic                                i_rst,
    input  wire logic                                i_reset_pin_n,
    input  wire logic                                i_test_pin,
    input  wire logic                                i_vpp_high,
    input  wire logic [7:0]                          i_port_a_lines,
    input  wire logic [6:0]                          i_port_b_lines,
    input  wire logic [3:0]                          i_port_c_lines,
    output logic      [7:0]                          o_port_a_lines,
    output logic      [7:0]                          o_port_a_oe,
    output logic      [6:0]                          o_port_b_lines,
    output logic      [6:0]                          o_port_b_oe,
    output logic      [3:0]                          o_port_c_lines,
    output logic      [3:0]                          o_port_c_oe,
    input  wire mode_select_pkg::port_ctl_s          i_port_ctl,
    input  wire mode_select_pkg::pwm_cfg_s [2:0]     i_pwm_cfg,
    input  wire logic                                i_timer0_ext_clock_sel,
    input  wire logic                                i_timer0_ext_gate_sel,
    input  wire logic                                i_irq_enable,
    input  wire logic [11:0]                         i_fetch_addr,
    output logic      [7:0]                          o_fetch_data,
    output logic                                     o_fetch_fuzzy,
    output logic [1:0]                               o_mode,
    output logic                                     o_core_reset,
    output logic                                     o_core_start,
    output logic                                     o_ext_irq,
    output logic      [7:0]                          o_port_a_in,
    output logic      [7:0]                          o_port_b_in,
    output logic      [3:0]                          o_port_c_in,
    output logic      [11:0]                         o_prog_addr,
    output logic      [3:0]                          o_config_index
);

    logic [mode_select_pkg::SYN_W-1:0] syn;
    logic [mode_select_pkg::SYN_W-1:0] prev_ff;
    logic [7:0]  pa;
    logic [6:0]  pb;
    logic [3:0]  pc;
    logic [6:0]  pb_prev;
    logic [3:0]  pc_prev;
    logic [7:0]  pa_prev;
    logic        phase_rise;
    logic        phase_fall;
    mode_select_pkg::op_mode_e mode_ff;
    mode_select_pkg::op_mode_e nxt_mode;
    logic [7:0]  mem [DEPTH];
    logic [2:0]  wave;
    logic [2:0]  wave_n;
    logic [2:0]  tick;

    // every pin level crosses two flops before use
    pin_sync #(
        .WIDTH (mode_select_pkg::SYN_W)
    ) u_pin_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async ({i_port_c_lines, i_port_b_lines, i_port_a_lines,
                   i_vpp_high, i_test_pin, i_reset_pin_n}),
        .o_sync  (syn)
    );

    assign pa      = syn[mode_select_pkg::SYN_PA_LSB +: 8];
    assign pb      = syn[mode_select_pkg::SYN_PB_LSB +: 7];
    assign pc      = syn[mode_select_pkg::SYN_PC_LSB +: 4];
    assign pa_prev = prev_ff[mode_select_pkg::SYN_PA_LSB +: 8];
    assign pb_prev = prev_ff[mode_select_pkg::SYN_PB_LSB +: 7];
    assign pc_prev = prev_ff[mode_select_pkg::SYN_PC_LSB +: 4];
    assign phase_rise = pc[mode_select_pkg::PC_PHASE_IRQ]
                        && !pc_prev[mode_select_pkg::PC_PHASE_IRQ];
    assign phase_fall = !pc[mode_select_pkg::PC_PHASE_IRQ]
                        && pc_prev[mode_select_pkg::PC_PHASE_IRQ];

    // previous synced levels for edge detection
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= syn;
        end
    end

    // mode decode from static levels; anything odd falls back to hold
    always_comb begin
        nxt_mode = mode_select_pkg::MODE_HOLD;                 // RULE19
        if (!syn[mode_select_pkg::SYN_TEST]) begin             // RULE10
            if (!syn[mode_select_pkg::SYN_RESET_N] && syn[mode_select_pkg::SYN_VPP]) begin
                nxt_mode = mode_select_pkg::MODE_PROG;         // RULE1 RULE2
            end else if (syn[mode_select_pkg::SYN_RESET_N]
                         && !syn[mode_select_pkg::SYN_VPP]) begin
                nxt_mode = mode_select_pkg::MODE_WORK;         // RULE7
            end
        end
    end

    // mode register and core reset; core is held outside working mode
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mode_ff      <= mode_select_pkg::MODE_HOLD;
            o_mode       <= mode_select_pkg::MODE_HOLD;
            o_core_reset <= 1'b1;
            o_core_start <= 1'b0;
        end else begin
            mode_ff      <= nxt_mode;
            o_mode       <= nxt_mode;
            o_core_reset <= (nxt_mode != mode_select_pkg::MODE_WORK);  // RULE3 RULE8
            o_core_start <= (nxt_mode == mode_select_pkg::MODE_WORK)
                            && (mode_ff != mode_select_pkg::MODE_WORK); // RULE8
        end
    end

    // address and config counters; clear wins over a same-cycle step
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_prog_addr    <= mode_select_pkg::ADDR_RST_VAL;
            o_config_index <= mode_select_pkg::CONF_RST_VAL;
        end else if (mode_ff == mode_select_pkg::MODE_PROG) begin   // RULE5
            if (pb[mode_select_pkg::PB_ADDR_CLR] && !pb_prev[mode_select_pkg::PB_ADDR_CLR]) begin
                o_prog_addr <= mode_select_pkg::ADDR_RST_VAL;     // RULE20
            end else if (pb[mode_select_pkg::PB_ADDR_INC]
                         && !pb_prev[mode_select_pkg::PB_ADDR_INC]) begin
                o_prog_addr <= o_prog_addr + 12'h0001;            // RULE4 RULE20
            end
            if (pb[mode_select_pkg::PB_CONF_CLR] && !pb_prev[mode_select_pkg::PB_CONF_CLR]) begin
                o_config_index <= mode_select_pkg::CONF_RST_VAL;
            end else if (pb[mode_select_pkg::PB_CONF_INC]
                         && !pb_prev[mode_select_pkg::PB_CONF_INC]) begin
                o_config_index <= o_config_index + 4'h1;
            end
        end
    end

    // programming write on falling phase; stores the last byte seen with phase
    // still high, because the programmer lets go of port a as phase falls
    always_ff @(posedge i_clock) begin
        if (mode_ff == mode_select_pkg::MODE_PROG && phase_fall) begin
            mem[o_prog_addr] <= pa_prev;                          // RULE3 RULE4 RULE6
        end
    end

    // fetch port for the core; region flag marks membership data
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_fetch_data  <= 8'h00;
            o_fetch_fuzzy <= 1'b0;
        end else begin
            o_fetch_data  <= mem[i_fetch_addr];                   // RULE8
            o_fetch_fuzzy <= (i_fetch_addr < mode_select_pkg::FUZZY_LIMIT); // RULE9
        end
    end

    // timer 0 tick from internal clock or a rising external edge, gated by run pin
    always_comb begin
        tick[0] = i_timer0_ext_clock_sel
                  ? (pa[mode_select_pkg::PA_T0_CLOCK] && !pa_prev[mode_select_pkg::PA_T0_CLOCK])
                  : 1'b1;                                         // RULE13
        if (i_timer0_ext_gate_sel && !pa[mode_select_pkg::PA_T0_RUN]) begin
            tick[0] = 1'b0;                                       // RULE14
        end
        tick[1] = 1'b1;
        tick[2] = 1'b1;
    end

    // three timer/pwm units; only timer 0 owns an external clear pin
    for (genvar u = 0; u < mode_select_pkg::NUM_PWM; u++) begin : g_pwm
        pwm_timer_unit #(
            .WIDTH (8)
        ) u_pwm (
            .i_clock   (i_clock),
            .i_rst     (i_rst),
            .i_enable  (i_pwm_cfg[u].enable && mode_ff == mode_select_pkg::MODE_WORK),
            .i_clear_n ((u == 0) ? pa[mode_select_pkg::PA_T0_CLEAR] : 1'b1),   // RULE12
            .i_tick    (tick[u]),
            .i_period  (i_pwm_cfg[u].period),
            .i_duty    (i_pwm_cfg[u].duty),
            .o_count   (),
            .o_wave    (wave[u]),
            .o_wave_n  (wave_n[u])
        );
    end

    // pin drivers; programming mode takes port a for data, the rest float
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_port_a_lines <= 8'h00;
            o_port_a_oe    <= 8'h00;
            o_port_b_lines <= 7'h00;
            o_port_b_oe    <= 7'h00;
            o_port_c_lines <= 4'h0;
            o_port_c_oe    <= 4'h0;
        end else if (nxt_mode == mode_select_pkg::MODE_PROG) begin
            o_port_a_lines <= mem[o_prog_addr];                   // RULE6
            o_port_a_oe    <= pc[mode_select_pkg::PC_PHASE_IRQ] ? 8'h00 : 8'hff;
            o_port_b_lines <= 7'h00;
            o_port_b_oe    <= 7'h00;                              // RULE5
            o_port_c_lines <= 4'h0;
            o_port_c_oe    <= 4'h0;
        end else if (nxt_mode == mode_select_pkg::MODE_WORK) begin
            o_port_a_lines <= i_port_ctl.out_a;                   // RULE16
            o_port_a_oe    <= i_port_ctl.dir_a;
            o_port_b_lines <= i_port_ctl.out_b;
            o_port_b_oe    <= i_port_ctl.dir_b;
            o_port_c_lines <= i_port_ctl.out_c;
            o_port_c_oe    <= i_port_ctl.dir_c;
            for (int k = 0; k < 3; k++) begin
                if (i_pwm_cfg[k].wave_on_pins) begin
                    o_port_c_lines[k+1] <= wave[k];               // RULE15
                    o_port_c_oe[k+1]    <= 1'b1;
                    o_port_a_lines[k+1] <= wave_n[k];
                    o_port_a_oe[k+1]    <= 1'b1;
                end
            end
            if (i_port_ctl.b7_owns_pin) begin
                o_port_a_lines[7] <= i_port_ctl.out_b[6];         // RULE17
                o_port_a_oe[7]    <= i_port_ctl.dir_b[6];
            end
        end else begin
            o_port_a_lines <= 8'h00;                              // RULE19
            o_port_a_oe    <= 8'h00;
            o_port_b_lines <= 7'h00;
            o_port_b_oe    <= 7'h00;
            o_port_c_lines <= 4'h0;
            o_port_c_oe    <= 4'h0;
        end
    end

    // input readback; bit 7 of both ports sees the same shared pin
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_port_a_in <= 8'h00;
            o_port_b_in <= 8'h00;
            o_port_c_in <= 4'h0;
        end else begin
            o_port_a_in <= pa;
            o_port_b_in <= {pa[7], pb};                           // RULE17
            o_port_c_in <= pc;
        end
    end

    // rising edge on the interrupt pin, working mode and input only
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_ext_irq <= 1'b0;
        end else begin
            o_ext_irq <= (mode_ff == mode_select_pkg::MODE_WORK) && i_irq_enable
                         && !i_port_ctl.dir_c[mode_select_pkg::PC_PHASE_IRQ]
                         && phase_rise;                           // RULE18
        end
    end

    chk_prog_decode: assert property (  // RULE1
        @(posedge i_clock) disable iff (i_rst)
        mode_ff == mode_select_pkg::MODE_PROG |->
            $past(syn[mode_select_pkg::SYN_VPP]) && !$past(syn[mode_select_pkg::SYN_RESET_N]))
        else $error("programming mode without reset low and supply high");

    chk_core_held: assert property (  // RULE3
        @(posedge i_clock) disable iff (i_rst)
        mode_ff != mode_select_pkg::MODE_WORK |-> o_core_reset)
        else $error("core released outside working mode");

    chk_addr_step: assert property (  // RULE20
        @(posedge i_clock) disable iff (i_rst)
        mode_ff == mode_select_pkg::MODE_PROG && pb[1] && !pb_prev[1]
            && !(pb[0] && !pb_prev[0]) |=> o_prog_addr == $past(o_prog_addr) + 12'h0001)
        else $error("address did not step by one");

    chk_addr_clear: assert property (  // RULE20
        @(posedge i_clock) disable iff (i_rst)
        mode_ff == mode_select_pkg::MODE_PROG && pb[0] && !pb_prev[0] |=> o_prog_addr == 12'h000)
        else $error("address not cleared");

    chk_portb_quiet: assert property (  // RULE5
        @(posedge i_clock) disable iff (i_rst)
        nxt_mode == mode_select_pkg::MODE_PROG |=> o_port_b_oe == 7'h00 && o_port_c_oe == 4'h0)
        else $error("port b or c driven during programming");

    chk_porta_read: assert property (  // RULE6
        @(posedge i_clock) disable iff (i_rst)
        nxt_mode == mode_select_pkg::MODE_PROG && !pc[0] |=> o_port_a_oe == 8'hff)
        else $error("port a not driven during read phase");

    chk_start_pulse: assert property (  // RULE8
        @(posedge i_clock) disable iff (i_rst)
        o_core_start |-> !o_core_reset ##1 !o_core_start)
        else $error("start pulse wrong");

    chk_fuzzy_flag: assert property (  // RULE9
        @(posedge i_clock) disable iff (i_rst)
        !$past(i_rst) |-> o_fetch_fuzzy == ($past(i_fetch_addr) < 12'h400))
        else $error("membership region flag wrong");

    chk_irq_mode: assert property (  // RULE18
        @(posedge i_clock) disable iff (i_rst)
        o_ext_irq |-> $past(mode_ff) == mode_select_pkg::MODE_WORK ##1 !o_ext_irq)
        else $error("interrupt outside working mode or too long");

endmodule // mode_select_prog_port

// file: sim/prog_model.sv
// programmer model: mode pins, memory strobes on port b, phase and data byte
// assumes the bench merges o_pa with the device port a drivers
`timescale 1ns/1ns
module prog_model (
    input  wire logic       i_clock,
    output logic            o_reset_n,
    output logic            o_test,
    output logic            o_vpp,
    output logic [7:0]      o_pa,
    output logic [6:0]      o_pb,
    output logic [3:0]      o_pc
);
    // strobes held 4 clocks high and 6 low, the high time one above the 3-clock minimum
    localparam int HOLD = 4;

    // power-up: everything low except phase, so the device never drives early
    initial begin
        {o_reset_n, o_test, o_vpp} = 3'b000;
        o_pa = 8'h00;
        o_pb = 7'h00;
        o_pc = 4'h1;
    end

    // static mode levels; test stays low except when the bench asks otherwise
    task automatic pins(input logic rn, input logic tst, input logic vpp);
        @(posedge i_clock);
        {o_reset_n, o_test, o_vpp} <= {rn, tst, vpp};
        repeat (6) @(posedge i_clock);
    endtask

    // one strobe pulse on a port b memory control line
    task automatic pulse(input int idx);
        @(posedge i_clock);
        o_pb[idx] <= 1'b1;
        repeat (HOLD) @(posedge i_clock);
        o_pb[idx] <= 1'b0;
        repeat (HOLD + 2) @(posedge i_clock);
    endtask

    // byte set up under phase high, stored by the phase fall; phase left low
    task automatic write_byte(input logic [7:0] data);
        @(posedge i_clock);
        o_pa <= data;
        repeat (HOLD) @(posedge i_clock);
        o_pc[0] <= 1'b0;
        o_pa <= ~data;  // released: no stale copy of the byte
        repeat (HOLD + 2) @(posedge i_clock);
    endtask

    // phase back high hands port a to the programmer again
    task automatic phase_high();
        @(posedge i_clock);
        o_pc[0] <= 1'b1;
        repeat (HOLD + 2) @(posedge i_clock);
    endtask
endmodule // prog_model

// file: sim/tb.sv
// self-checking bench for the mode select and program port block
// assumes the programmer model owns all pins; core side inputs idle except fetch address, interrupt enable and unit 0 set-up
`timescale 1ns/1ns
module tb;
    logic                                i_clock;
    logic                                i_rst;
    logic                                rst_n_pin, test_pin, vpp_pin;
    logic [7:0]                          mdl_pa, pa_pin, dev_pa, dev_pa_oe;
    logic [6:0]                          mdl_pb;
    logic [3:0]                          mdl_pc, dev_pc;
    mode_select_pkg::port_ctl_s          port_ctl = '0;
    mode_select_pkg::pwm_cfg_s [2:0]     pwm_cfg = '0;
    logic [11:0]                         fetch_addr = 12'h0000;
    logic [7:0]                          fetch_data;
    logic                                fetch_fuzzy, core_reset, core_start, ext_irq;
    logic                                irq_en = 1'b0;
    logic [1:0]                          mode;
    logic [11:0]                         prog_addr;
    logic [3:0]                          conf_idx;
    int                                  error_cnt = 0;
    int                                  compares = 0;
    int                                  starts = 0, irqs = 0;

    // device enable wins a bit; released model bits never show stale data
    assign pa_pin = (dev_pa_oe & dev_pa) | (~dev_pa_oe & mdl_pa);

    prog_model i_prog_model (.i_clock(i_clock), .o_reset_n(rst_n_pin), .o_test(test_pin),
        .o_vpp(vpp_pin), .o_pa(mdl_pa), .o_pb(mdl_pb), .o_pc(mdl_pc));

    mode_select_prog_port i_mode_select_prog_port (.i_clock(i_clock), .i_rst(i_rst),
        .i_reset_pin_n(rst_n_pin), .i_test_pin(test_pin), .i_vpp_high(vpp_pin),
        .i_port_a_lines(pa_pin), .i_port_b_lines(mdl_pb), .i_port_c_lines(mdl_pc),
        .o_port_a_lines(dev_pa), .o_port_a_oe(dev_pa_oe), .o_port_b_lines(), .o_port_b_oe(),
        .o_port_c_lines(dev_pc), .o_port_c_oe(), .i_port_ctl(port_ctl), .i_pwm_cfg(pwm_cfg),
        .i_timer0_ext_clock_sel(1'b0), .i_timer0_ext_gate_sel(1'b0), .i_irq_enable(irq_en),
        .i_fetch_addr(fetch_addr), .o_fetch_data(fetch_data), .o_fetch_fuzzy(fetch_fuzzy),
        .o_mode(mode), .o_core_reset(core_reset), .o_core_start(core_start),
        .o_ext_irq(ext_irq),
        .o_port_a_in(), .o_port_b_in(), .o_port_c_in(), .o_prog_addr(prog_addr),
        .o_config_index(conf_idx));

    // one-cycle pulses counted off the edge, so each is seen exactly once
    always @(negedge i_clock) begin
        starts += core_start;
        irqs += ext_irq;
    end

    // compare away from the clock edge so the edge's updates have landed
    task automatic check(input logic ok, input string what);
        #1;
        compares++;
        if (!ok) begin
            error_cnt++;
            $display("[FAIL] %0t ns: %s", $time, what);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // reset pin low first, supply raised only afterwards
    task automatic t_prog_entry();
        i_prog_model.pins(1'b0, 1'b0, 1'b0);
        check(mode === 2'd0 && core_reset === 1'b1, "all low is not hold");
        i_prog_model.pins(1'b0, 1'b0, 1'b1);
        check(mode === 2'd1 && core_reset === 1'b1, "no programming mode");
        $display("test prog_entry done");
    endtask

    // address and configuration counters step and clear
    task automatic t_counters();
        i_prog_model.pulse(mode_select_pkg::PB_ADDR_INC);
        i_prog_model.pulse(mode_select_pkg::PB_ADDR_INC);
        check(prog_addr === 12'h002, "address not stepped twice");
        i_prog_model.pulse(mode_select_pkg::PB_ADDR_CLR);
        check(prog_addr === 12'h000, "address not cleared");
        i_prog_model.pulse(mode_select_pkg::PB_CONF_INC);
        check(conf_idx === 4'h1, "config index not stepped");
        i_prog_model.pulse(mode_select_pkg::PB_CONF_CLR);
        check(conf_idx === 4'h0, "config index not cleared");
        $display("test counters done");
    endtask

    // two bytes written, each read back while phase is low
    task automatic t_write_read();
        i_prog_model.write_byte(8'h5A);
        check(dev_pa_oe === 8'hFF && dev_pa === 8'h5A, "byte 0 not read back");
        i_prog_model.phase_high();
        check(dev_pa_oe === 8'h00, "port a still driven");
        i_prog_model.pulse(mode_select_pkg::PB_ADDR_INC);
        i_prog_model.write_byte(8'hC3);
        check(dev_pa_oe === 8'hFF && dev_pa === 8'hC3, "byte 1 not read back");
        i_prog_model.phase_high();
        $display("test write_read done");
    endtask

    task automatic fetch(input logic [11:0] a, input logic [7:0] d, input logic fz);
        @(posedge i_clock);
        fetch_addr <= a;
        repeat (2) @(posedge i_clock);
        check(fetch_data === d && fetch_fuzzy === fz, "fetch mismatch");
    endtask

    // working mode runs the loaded bytes; strobes no longer count
    task automatic t_work();
        i_prog_model.pins(1'b1, 1'b0, 1'b0);
        check(mode === 2'd2 && core_reset === 1'b0, "no working mode");
        check(starts == 1, "no start pulse");
        fetch(12'h000, 8'h5A, 1'b1);
        fetch(12'h001, 8'hC3, 1'b1);
        @(posedge i_clock);
        fetch_addr <= 12'h3FF;
        repeat (2) @(posedge i_clock);
        check(fetch_fuzzy === 1'b1, "last membership slot");
        @(posedge i_clock);
        fetch_addr <= 12'h400;
        repeat (2) @(posedge i_clock);
        check(fetch_fuzzy === 1'b0, "first program slot");
        i_prog_model.pulse(mode_select_pkg::PB_ADDR_INC);
        check(prog_addr === 12'h001, "strobe counted in work");
        // phase pin falls then rises: only the rise may raise the interrupt
        @(posedge i_clock);
        irq_en <= 1'b1;
        i_prog_model.write_byte(8'h00);
        i_prog_model.phase_high();
        check(irqs == 1, "no interrupt pulse");
        // unit 0 on pins: full duty then zero duty, pair must stay opposite
        @(posedge i_clock);
        pwm_cfg[0] <= {1'b1, 1'b1, 8'h03, 8'hFF};
        repeat (3) @(posedge i_clock);
        check(dev_pc[1] === 1'b1 && dev_pa[1] === 1'b0 && dev_pa_oe === 8'h02, "pwm high");
        @(posedge i_clock);
        pwm_cfg[0].duty <= 8'h00;
        repeat (3) @(posedge i_clock);
        check(dev_pc[1] === 1'b0 && dev_pa[1] === 1'b1, "pwm low");
        i_prog_model.pins(1'b1, 1'b1, 1'b0);
        check(mode === 2'd0 && core_reset === 1'b1, "test high not refused");
        $display("test work done");
    endtask

    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    // whole sequence needs under two hundred clocks; 5000 means a hang
    initial begin
        repeat (5000) @(posedge i_clock);
        error_cnt++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        i_rst = 1'b1;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        t_prog_entry();
        t_counters();
        t_write_read();
        t_work();
        give_verdict();
    end
endmodule // tb
